// *** pic_ctrl.sv ***
// interrupt control: sources, enables, pending, host control and acceptance
`timescale 1ns/1ps
module pic_ctrl (
  input  logic        clk,
  input  logic        rst,
  input  logic        reset_pin_n,
  input  logic        ext_irq_one_n,
  input  logic        ext_irq_two_n,
  input  logic        display_irq,
  input  logic        bus_fault_in,
  input  logic        local_ready_in,
  input  logic        local_cycle,
  input  logic        pixel_valid,
  input  logic        pixel_in_window,
  input  logic [1:0]  window_mode,
  input  logic        illegal_opcode_irq,
  input  logic        instr_done,
  input  logic        interruptible_point,
  input  logic        enable_irqs_instr,
  input  logic        disable_irqs_instr,
  input  logic        write_status_instr,
  input  logic [31:0] status_wdata,
  input  logic        reg_wr,
  input  logic        reg_rd,
  input  logic [2:0]  reg_sel,
  input  logic [15:0] reg_wdata,
  input  logic        host_wr_high,
  input  logic        host_wr_low,
  input  logic [15:0] host_wdata,
  output logic [15:0] reg_rdata,
  output logic [31:0] status_word,
  output logic [31:0] saved_status,
  output logic        irq_take,
  output logic [31:0] irq_vector,
  output logic [3:0]  irq_source,
  output logic        nonmaskable_context_sel,
  output logic        core_reset,
  output logic        halt,
  output logic        host_irq_out,
  output logic [15:0] host_control_high_reg,
  output logic [15:0] host_control_low_reg
);
  logic [2:0]  pins_sync;
  logic        reset_pin_s;
  logic        external_irq_one;
  logic        external_irq_two;
  logic        display_lvl;
  logic        display_lvl_q;
  logic        soft_rst;
  logic [31:0] status_reg;
  logic [15:0] irq_enable_reg;
  logic        display_irq_pend;
  logic        window_violation_pend;
  logic        ss_pend;
  logic        ill_pend;
  logic        bf_pend;
  logic        window_violation_irq;
  logic        bus_fault_event;
  logic        display_event;
  logic        take_point;
  logic        global_irq_enable;
  logic [pic_pkg::SRC_COUNT-1:0] req;
  logic        req_any;
  logic [3:0]  req_win;
  logic        accept;
  logic [15:0] irq_pending_reg;
  logic        core_wr_hctlh;
  logic        core_wr_hctll;
  pic_pkg::pic_state_t state;
  pic_pkg::pic_state_t next_state;

  pic_sync #(
    .WIDTH (3),
    .INIT  (1'b1)
  ) u_pin_sync (
    .clk   (clk),
    .rst   (rst),
    .pin   ({reset_pin_n, ext_irq_two_n, ext_irq_one_n}), // R26
    .level (pins_sync)
  );

  // display comes from the video timing clock, so it is resynchronised too
  pic_sync #(
    .WIDTH (1),
    .INIT  (1'b0)
  ) u_disp_sync (
    .clk   (clk),
    .rst   (rst),
    .pin   (display_irq), // R22
    .level (display_lvl)
  );

  assign reset_pin_s      = ~pins_sync[2];              // R04
  assign external_irq_two = ~pins_sync[1];              // R03
  assign external_irq_one = ~pins_sync[0];              // R03
  assign soft_rst = reset_pin_s | host_control_high_reg[pic_pkg::HC_RST]; // R12
  assign global_irq_enable = status_reg[pic_pkg::ST_IE];
  assign take_point = instr_done | interruptible_point; // R24
  assign display_event = display_lvl & ~display_lvl_q;
  assign bus_fault_event = local_cycle & bus_fault_in & local_ready_in; // R01
  assign window_violation_irq = pixel_valid & (  // R19
    (window_mode == pic_pkg::WIN_MODE_INSIDE  &  pixel_in_window) |
    (window_mode == pic_pkg::WIN_MODE_OUTSIDE & ~pixel_in_window));
  assign core_wr_hctlh = reg_wr & (reg_sel == pic_pkg::SEL_HCTLH);
  assign core_wr_hctll = reg_wr & (reg_sel == pic_pkg::SEL_HCTLL);

  always_comb begin
    irq_pending_reg = 16'h0000; // R10
    irq_pending_reg[pic_pkg::EN_WV] = window_violation_pend;
    irq_pending_reg[pic_pkg::EN_DI] = display_irq_pend;
    irq_pending_reg[pic_pkg::EN_HI] = host_control_low_reg[pic_pkg::HL_HOST_TO_CPU_IRQ_BIT];
    irq_pending_reg[pic_pkg::EN_X2] = external_irq_two; // R27
    irq_pending_reg[pic_pkg::EN_X1] = external_irq_one;
  end

  // unmaskable sources never see the enables; the five gated ones need both
  always_comb begin
    req = '0;
    req[pic_pkg::SRC_BF]  = bf_pend;                                        // R16
    req[pic_pkg::SRC_NMI] = host_control_high_reg[pic_pkg::HC_NMI];         // R13
    req[pic_pkg::SRC_HI]  = global_irq_enable & irq_enable_reg[pic_pkg::EN_HI] &
                            irq_pending_reg[pic_pkg::EN_HI];                // R20
    req[pic_pkg::SRC_DI]  = global_irq_enable & irq_enable_reg[pic_pkg::EN_DI] &
                            irq_pending_reg[pic_pkg::EN_DI];                // R05
    req[pic_pkg::SRC_WV]  = global_irq_enable & irq_enable_reg[pic_pkg::EN_WV] &
                            irq_pending_reg[pic_pkg::EN_WV];                // R09
    req[pic_pkg::SRC_X1]  = global_irq_enable & irq_enable_reg[pic_pkg::EN_X1] &
                            irq_pending_reg[pic_pkg::EN_X1];
    req[pic_pkg::SRC_X2]  = global_irq_enable & irq_enable_reg[pic_pkg::EN_X2] &
                            irq_pending_reg[pic_pkg::EN_X2];
    req[pic_pkg::SRC_SS]  = ss_pend;                                        // R06
    req[pic_pkg::SRC_ILL] = ill_pend;                                       // R16
  end

  pic_prio #(
    .COUNT  (pic_pkg::SRC_COUNT)
  ) u_prio (
    .req    (req),
    .any    (req_any),
    .winner (req_win)
  );

  assign accept = (state == pic_pkg::PIC_IDLE) & take_point & req_any &
                  ~soft_rst & ~halt; // R24

  always_comb begin
    next_state = state;
    case (state)
      pic_pkg::PIC_IDLE:  if (accept) next_state = pic_pkg::PIC_ENTRY;
      pic_pkg::PIC_ENTRY: next_state = pic_pkg::PIC_IDLE;
      default:            next_state = pic_pkg::PIC_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) state <= pic_pkg::PIC_IDLE;
    else if (soft_rst) state <= pic_pkg::PIC_IDLE;
    else state <= next_state;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) display_lvl_q <= 1'b0;
    else display_lvl_q <= display_lvl;
  end

  // sticky flags: a new event in the clearing cycle wins over the clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      display_irq_pend      <= 1'b0;
      window_violation_pend <= 1'b0;
      ss_pend               <= 1'b0;
      ill_pend              <= 1'b0;
      bf_pend               <= 1'b0;
    end else if (soft_rst) begin
      display_irq_pend      <= 1'b0;
      window_violation_pend <= 1'b0;
      ss_pend               <= 1'b0;
      ill_pend              <= 1'b0;
      bf_pend               <= 1'b0;
    end else begin
      if (display_event) display_irq_pend <= 1'b1;
      else if ((accept & req_win == pic_pkg::SRC_DI) |
               (reg_wr & reg_sel == pic_pkg::SEL_PEND & ~reg_wdata[pic_pkg::EN_DI]))
        display_irq_pend <= 1'b0;
      if (window_violation_irq) window_violation_pend <= 1'b1;
      else if ((accept & req_win == pic_pkg::SRC_WV) |
               (reg_wr & reg_sel == pic_pkg::SEL_PEND & ~reg_wdata[pic_pkg::EN_WV]))
        window_violation_pend <= 1'b0;
      if (instr_done & status_reg[pic_pkg::ST_SS]) ss_pend <= 1'b1; // R06
      else if (accept | ~status_reg[pic_pkg::ST_SS]) ss_pend <= 1'b0;
      if (illegal_opcode_irq) ill_pend <= 1'b1;
      else if (accept & req_win == pic_pkg::SRC_ILL) ill_pend <= 1'b0;
      if (bus_fault_event) bf_pend <= 1'b1; // R01
      else if (accept & req_win == pic_pkg::SRC_BF) bf_pend <= 1'b0;
    end
  end

  // entry rewrite beats a status store, which beats the enable instructions
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_reg   <= pic_pkg::STATUS_RST;
      saved_status <= pic_pkg::STATUS_RST;
    end else if (soft_rst) begin
      status_reg   <= pic_pkg::STATUS_RST;
      saved_status <= pic_pkg::STATUS_RST;
    end else if (accept) begin
      saved_status <= status_reg;
      saved_status[pic_pkg::ST_IX] <= interruptible_point & ~instr_done; // R07
      saved_status[pic_pkg::ST_BF] <= (req_win == pic_pkg::SRC_BF);      // R08
      status_reg   <= pic_pkg::STATUS_RST; // R25
    end else if (write_status_instr) begin
      status_reg <= status_wdata;
    end else if (enable_irqs_instr) begin
      status_reg[pic_pkg::ST_IE] <= 1'b1; // R21
    end else if (disable_irqs_instr) begin
      status_reg[pic_pkg::ST_IE] <= 1'b0; // R21
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) irq_enable_reg <= pic_pkg::ENABLE_RST;
    else if (soft_rst) irq_enable_reg <= pic_pkg::ENABLE_RST;
    else if (reg_wr & reg_sel == pic_pkg::SEL_ENABLE)
      irq_enable_reg <= reg_wdata & pic_pkg::ENABLE_MASK; // R09
  end

  // host writes win over the core in the same cycle; nonmaskable set wins over its clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      host_control_high_reg <= pic_pkg::HCTL_RST;
    end else if (reset_pin_s) begin
      host_control_high_reg <= pic_pkg::HCTL_RST;
    end else if (host_wr_high) begin
      host_control_high_reg <= host_wdata; // R11
    end else if (core_wr_hctlh) begin
      host_control_high_reg <= reg_wdata; // R11
    end else if (host_control_high_reg[pic_pkg::HC_RST]) begin
      host_control_high_reg <= pic_pkg::HCTL_RST; // R12
    end else if (accept & req_win == pic_pkg::SRC_NMI) begin
      host_control_high_reg[pic_pkg::HC_NMI] <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) host_control_low_reg <= pic_pkg::HCTL_RST;
    else if (soft_rst) host_control_low_reg <= pic_pkg::HCTL_RST;
    else if (host_wr_low) host_control_low_reg <= host_wdata; // R18
    else if (core_wr_hctll) host_control_low_reg <= reg_wdata; // R11
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_take   <= 1'b0;
      irq_vector <= pic_pkg::VEC_TOP;
      irq_source <= 4'h0;
    end else if (soft_rst) begin
      irq_take   <= 1'b0;
      irq_vector <= pic_pkg::trap_vector(pic_pkg::TRAP_RST); // R17
      irq_source <= 4'h0;
    end else begin
      irq_take <= accept;
      if (accept) begin
        irq_vector <= pic_pkg::trap_vector(pic_pkg::src_trap(req_win)); // R23
        irq_source <= req_win;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      core_reset              <= 1'b1;
      halt                    <= 1'b0;
      host_irq_out            <= 1'b0;
      nonmaskable_context_sel <= 1'b0;
      status_word             <= pic_pkg::STATUS_RST;
    end else begin
      core_reset              <= soft_rst; // R04
      halt                    <= host_control_high_reg[pic_pkg::HC_HLT]; // R15
      host_irq_out            <= host_control_low_reg[pic_pkg::HL_INTOUT]; // R02
      nonmaskable_context_sel <= host_control_high_reg[pic_pkg::HC_NONMASKABLE_CONTEXT_SEL]; // R14
      status_word             <= status_reg;
    end
  end

  // read data lands one cycle after the read strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      if (reg_sel == pic_pkg::SEL_STATUS) reg_rdata <= status_reg[15:0];
      else if (reg_sel == pic_pkg::SEL_ENABLE) reg_rdata <= irq_enable_reg;
      else if (reg_sel == pic_pkg::SEL_PEND) reg_rdata <= irq_pending_reg;
      else if (reg_sel == pic_pkg::SEL_HCTLH) reg_rdata <= host_control_high_reg;
      else if (reg_sel == pic_pkg::SEL_HCTLL) reg_rdata <= host_control_low_reg;
      else reg_rdata <= 16'h0000;
    end
  end

  // a pending fault at an idle take point must win at once
  sequence s_fault_ready;
    bf_pend && take_point && state == pic_pkg::PIC_IDLE && !halt;
  endsequence

  sequence s_fault_taken;
    irq_take && irq_source == pic_pkg::SRC_BF && saved_status[pic_pkg::ST_BF];
  endsequence

  // pin low for five samples must show up as pending
  sequence s_ext_one_held;
    $fell(ext_irq_one_n) ##1 (ext_irq_one_n == 1'b0)[*4];
  endsequence

  sequence s_entry_quiet;
    !status_reg[pic_pkg::ST_IE] && !status_reg[pic_pkg::ST_SS] ##1 !irq_take;
  endsequence

  a_bus_fault_take: assert property (@(posedge clk) disable iff (rst || soft_rst) // R01
    s_fault_ready |=> s_fault_taken)
    else $error("bus fault not taken first");
  a_host_out_follow: assert property (@(posedge clk) disable iff (rst) // R02
    host_irq_out == $past(host_control_low_reg[pic_pkg::HL_INTOUT]))
    else $error("host interrupt output does not follow control bit");
  a_ext_level: assert property (@(posedge clk) disable iff (rst) // R27
    s_ext_one_held |-> irq_pending_reg[pic_pkg::EN_X1])
    else $error("external pending missing after low level");
  a_reset_pin: assert property (@(posedge clk) disable iff (rst) // R04
    reset_pin_s |=> core_reset && !irq_take)
    else $error("reset pin did not reset core");
  a_ie_blocks: assert property (@(posedge clk) disable iff (rst || soft_rst) // R05
    (accept && !global_irq_enable) |=>
      (irq_source < pic_pkg::SRC_HI || irq_source > pic_pkg::SRC_X2))
    else $error("gated source taken with global enable low");
  a_ix_on_point: assert property (@(posedge clk) disable iff (rst || soft_rst) // R07
    (accept && interruptible_point && !instr_done) |=> saved_status[pic_pkg::ST_IX])
    else $error("mid-instruction flag not saved");
  a_entry_clears: assert property (@(posedge clk) disable iff (rst || soft_rst) // R25
    accept |=> s_entry_quiet)
    else $error("entry did not clear enables or took twice");
  a_prio_nmi: assert property (@(posedge clk) disable iff (rst || soft_rst) // R17
    (accept && host_control_high_reg[pic_pkg::HC_NMI] && !bf_pend) |=>
      irq_vector == pic_pkg::trap_vector(pic_pkg::TRAP_NMI))
    else $error("nonmaskable lost priority");
  a_halt_follow: assert property (@(posedge clk) disable iff (rst) // R15
    halt |=> !irq_take)
    else $error("accepted while halted");
endmodule : pic_ctrl

// *** pic_pkg.sv ***
// constants, types and vector helper for the processor interrupt control block
// Function
// (R01) bus fault: fault and ready high in cycle
// (R02) host interrupt output follows host control bits
// (R03) external inputs level-sensitive, active low
// (R04) reset pin low resets the device
// (R05) global enable gates the enable register
// (R06) single-step after each instruction, ignores enable
// (R07) interruptible-point entry sets mid-instruction flag
// (R08) bus-fault entry sets bus-fault flag
// (R09) enable bits at 11, 10, 9, 2, 1
// (R10) pending bits at same positions as enables
// (R11) host and core both write host control
// (R12) host control high bit 7 resets device
// (R13) host control high bit 8 raises nonmaskable
// (R14) host control high bit 9 selects context save
// (R15) host control high bit 15 halts processor
// (R16) reset, fault, nonmaskable, illegal opcode unmaskable
// (R17) fixed priority reset down to illegal opcode
// (R18) host request comes from host control bit
// (R19) window violation by window mode one/two
// (R20) priorities four to eight need global enable
// (R21) enable/disable instructions set/clear global enable
// (R22) display request from video timing hardware
// (R23) vectors descend 32 bits from the top
// (R24) accept at instruction end or interruptible point
// (R25) entry clears maskable enables and single-step
// (R26) one state sync, up to two async
// (R27) external pending flags track synchronised level
package pic_pkg;
  localparam int unsigned ST_IE  = 21;
  localparam int unsigned ST_SS  = 22;
  localparam int unsigned ST_IX  = 25;
  localparam int unsigned ST_BF  = 26;
  localparam int unsigned EN_WV  = 11;
  localparam int unsigned EN_DI  = 10;
  localparam int unsigned EN_HI  = 9;
  localparam int unsigned EN_X2  = 2;
  localparam int unsigned EN_X1  = 1;
  localparam int unsigned HC_RST = 7;
  localparam int unsigned HC_NMI = 8;
  localparam int unsigned HC_NONMASKABLE_CONTEXT_SEL = 9;
  localparam int unsigned HC_HLT = 15;
  localparam int unsigned HL_HOST_TO_CPU_IRQ_BIT  = 3;
  localparam int unsigned HL_INTOUT = 7;
  localparam logic [31:0] STATUS_RST  = 32'h0000_0000;
  localparam logic [15:0] ENABLE_RST  = 16'h0000;
  localparam logic [15:0] HCTL_RST    = 16'h0000;
  localparam logic [15:0] ENABLE_MASK = 16'h0e06;
  localparam logic [2:0] SEL_STATUS = 3'h0;
  localparam logic [2:0] SEL_ENABLE = 3'h1;
  localparam logic [2:0] SEL_PEND   = 3'h2;
  localparam logic [2:0] SEL_HCTLH  = 3'h3;
  localparam logic [2:0] SEL_HCTLL  = 3'h4;
  localparam logic [1:0] WIN_MODE_INSIDE  = 2'h1;
  localparam logic [1:0] WIN_MODE_OUTSIDE = 2'h2;
  localparam int unsigned SRC_COUNT = 9;
  // source index in priority order, index 0 is highest after reset
  typedef enum logic [3:0] {
    SRC_BF = 4'h0, SRC_NMI = 4'h1, SRC_HI = 4'h2, SRC_DI = 4'h3, SRC_WV = 4'h4,
    SRC_X1 = 4'h5, SRC_X2 = 4'h6, SRC_SS = 4'h7, SRC_ILL = 4'h8
  } pic_src_t;
  typedef enum logic [1:0] {
    PIC_IDLE  = 2'b01,
    PIC_ENTRY = 2'b10
  } pic_state_t;
  localparam logic [31:0] VEC_TOP   = 32'hffff_ffe0;
  localparam logic [15:0] TRAP_RST  = 16'h0000;
  localparam logic [15:0] TRAP_X1   = 16'h0001;
  localparam logic [15:0] TRAP_X2   = 16'h0002;
  localparam logic [15:0] TRAP_NMI  = 16'h0008;
  localparam logic [15:0] TRAP_HI   = 16'h0009;
  localparam logic [15:0] TRAP_DI   = 16'h000a;
  localparam logic [15:0] TRAP_WV   = 16'h000b;
  localparam logic [15:0] TRAP_ILL  = 16'h001e;
  localparam logic [15:0] TRAP_SS   = 16'h0020;
  localparam logic [15:0] TRAP_BF   = 16'h0021;

  // trap numbers 0 upward descend from the top, one 32-bit slot each
  function automatic logic [31:0] trap_vector(input logic [15:0] trap);
    trap_vector = VEC_TOP - {11'h000, trap, 5'h00}; // R23
  endfunction : trap_vector

  function automatic logic [15:0] src_trap(input logic [3:0] src);
    case (src)
      SRC_BF:  src_trap = TRAP_BF;
      SRC_NMI: src_trap = TRAP_NMI;
      SRC_HI:  src_trap = TRAP_HI;
      SRC_DI:  src_trap = TRAP_DI;
      SRC_WV:  src_trap = TRAP_WV;
      SRC_X1:  src_trap = TRAP_X1;
      SRC_X2:  src_trap = TRAP_X2;
      SRC_SS:  src_trap = TRAP_SS;
      default: src_trap = TRAP_ILL;
    endcase
  endfunction : src_trap
endpackage : pic_pkg

// *** pic_sync.sv ***
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pic_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic        INIT  = 1'b0
) (
  input  logic             clk,
  input  logic             rst,
  input  logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);
  logic [WIDTH-1:0] ff1;
  logic [WIDTH-1:0] ff2;
  logic [WIDTH-1:0] ff3;

  // a change counts only when the second and third stages agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ff1   <= {WIDTH{INIT}};
      ff2   <= {WIDTH{INIT}};
      ff3   <= {WIDTH{INIT}};
      level <= {WIDTH{INIT}};
    end else begin
      ff1 <= pin;
      ff2 <= ff1;
      ff3 <= ff2;
      for (int i = 0; i < WIDTH; i++) begin
        if (ff2[i] == ff3[i]) level[i] <= ff3[i];
      end
    end
  end
endmodule : pic_sync

// *** pic_prio.sv ***
// fixed priority resolver, lowest index wins
`timescale 1ns/1ps
module pic_prio #(
  parameter int unsigned COUNT = 9
) (
  input  logic [COUNT-1:0] req,
  output logic             any,
  output logic [3:0]       winner
);
  always_comb begin
    any    = 1'b0;
    winner = 4'h0;
    for (int i = COUNT - 1; i >= 0; i--) begin
      if (req[i]) begin
        any    = 1'b1;
        winner = 4'(i); // R17
      end
    end
  end
endmodule : pic_prio

// *** pic_far.sv ***
// far-side model: external requesters, local memory bus and reset pin
`timescale 1ns/1ps
module pic_far (
  input  wire logic       clk,
  input  wire logic [3:0] req,
  output logic            bus_fault_in = 1'b0,
  output logic            local_ready_in = 1'b0,
  output logic            local_cycle = 1'b0,
  output logic            ext_irq_one_n = 1'b1,
  output logic            ext_irq_two_n = 1'b1,
  output logic            reset_pin_n = 1'b1
);
  // req bits: 0 fault, 1 ext one, 2 ext two, 3 pin reset
  logic [3:0] seen = 4'h0;
  logic       beat = 1'b0;
  always @(posedge clk) seen <= req;
  // slow memory: wait state every other cycle, fault line high while not ready; req bit 0 holds fault and ready both high
  always @(negedge clk) begin
    beat           <= ~beat;
    local_cycle    <= 1'b1;
    local_ready_in <= seen[0] | beat;
    bus_fault_in   <= seen[0] | ~beat;
    ext_irq_one_n  <= ~seen[1];
    ext_irq_two_n  <= ~seen[2];
    reset_pin_n    <= ~seen[3];
  end
endmodule : pic_far

// *** tb_processor_interrupt_control.sv ***
// self-checking bench for the processor interrupt control block
`timescale 1ns/1ps
module tb_processor_interrupt_control;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] pul = 12'h000;
  logic        dsp = 1'b0;
  logic        inwin = 1'b0;
  logic [1:0]  wmode = 2'h0;
  logic [2:0]  sel = 3'h0;
  logic [15:0] wdat = 16'h0000;
  logic [15:0] hdat = 16'h0000;
  logic [31:0] sdat = 32'h0000_0000;
  logic [3:0]  freq = 4'h0;
  logic [31:0] seed = 32'h0000_0045;
  logic [31:0] x;
  logic        flt, rdy, lcyc, x1n, x2n, rpn;
  logic        irq_take, nonmaskable_context_sel, core_reset, halt, host_irq_out;
  logic [15:0] reg_rdata, host_control_high_reg, host_control_low_reg;
  logic [31:0] status_word, saved_status, irq_vector;
  logic [3:0]  irq_source;
  int          n_fail = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          e;
  int          expq[$];
  // trap number per source code, highest priority first
  int          trap_of[9] = '{33, 8, 9, 10, 11, 1, 2, 32, 30};

  always #5 clk = ~clk;

  pic_far far_u (.clk, .req(freq), .bus_fault_in(flt), .local_ready_in(rdy),
    .local_cycle(lcyc), .ext_irq_one_n(x1n), .ext_irq_two_n(x2n), .reset_pin_n(rpn));

  pic_ctrl dut_u (.clk, .rst, .reset_pin_n(rpn), .ext_irq_one_n(x1n), .ext_irq_two_n(x2n),
    .display_irq(dsp), .bus_fault_in(flt), .local_ready_in(rdy), .local_cycle(lcyc),
    .pixel_valid(pul[10]), .pixel_in_window(inwin), .window_mode(wmode),
    .illegal_opcode_irq(pul[5]), .instr_done(pul[0]), .interruptible_point(pul[1]),
    .enable_irqs_instr(pul[2]), .disable_irqs_instr(pul[3]), .write_status_instr(pul[4]),
    .status_wdata(sdat), .reg_wr(pul[6]), .reg_rd(pul[7]), .reg_sel(sel), .reg_wdata(wdat),
    .host_wr_high(pul[8]), .host_wr_low(pul[9]), .host_wdata(hdat), .reg_rdata,
    .status_word, .saved_status, .irq_take, .irq_vector, .irq_source,
    .nonmaskable_context_sel, .core_reset, .halt, .host_irq_out,
    .host_control_high_reg, .host_control_low_reg);

  task automatic summarize();
    if (n_fail == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // one-cycle pulse on a strobe; the gap after it keeps strobes two cycles apart
  task automatic strobe(input int b);
    @(negedge clk);
    pul = 12'h001 << b;
    @(negedge clk);
    pul = 12'h000;
  endtask : strobe

  task automatic wr(input logic [2:0] s, input logic [15:0] d);
    sel = s;
    wdat = d;
    strobe(6);
  endtask : wr

  task automatic rd(input logic [2:0] s, input logic [15:0] d);
    sel = s;
    strobe(7);
    chk({16'h0000, reg_rdata}, {16'h0000, d});
  endtask : rd

  task automatic hw(input logic h, input logic [15:0] d);
    hdat = d;
    strobe(h ? 8 : 9);
  endtask : hw

  // four take points; every acceptance must match the queue, leftovers are misses
  task automatic take(input int b);
    repeat (4) strobe(b);
    repeat (3) @(negedge clk);
    chk(expq.size(), 32'h0);
    expq.delete();
  endtask : take

  task automatic wt(input logic v);
    for (int i = 0; i < 12 && core_reset !== v; i++) @(negedge clk);
    chk({31'h0, core_reset}, {31'h0, v});
  endtask : wt

  always @(negedge clk) begin
    if (!rst && irq_take === 1'b1) begin
      if (expq.size() == 0) begin
        chk({28'h0, irq_source}, 32'hffff_ffff);
      end else begin
        e = expq.pop_front();
        chk({28'h0, irq_source}, e[3:0]);
        chk(irq_vector, 32'hffff_ffe0 - 32'(trap_of[e[3:0]]) * 32'h20);
        chk({30'h0, saved_status[26:25]}, e[5:4]);
        // status_word trails the status register by one cycle
        @(negedge clk);
        chk({30'h0, status_word[22:21]}, 32'h0);
      end
    end
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_fail++;
      summarize();
    end
  end

  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    chk(irq_vector, 32'hffff_ffe0);
    rd(3'h0, 16'h0000);
    rd(3'h1, 16'h0000);
    rd(3'h2, 16'h0000);
    rd(3'h3, 16'h0000);
    repeat (4) begin
      x = xs();
      wr(3'h1, x[15:0]);
      rd(3'h1, x[15:0] & 16'h0e06);
    end
    freq = 4'h1;
    @(negedge clk);
    freq = 4'h0;
    expq.push_back(32'h20);
    take(0);
    strobe(5);
    expq.push_back(32'h18);
    take(1);
    wr(3'h1, 16'h0e06);
    freq = 4'h2;
    repeat (8) @(negedge clk);
    take(0);
    rd(3'h2, 16'h0002);
    strobe(2);
    expq.push_back(5);
    take(0);
    hw(1'b0, 16'h0008);
    rd(3'h2, 16'h0202);
    strobe(2);
    expq.push_back(2);
    take(0);
    hw(1'b0, 16'h0000);
    freq = 4'h4;
    repeat (8) @(negedge clk);
    strobe(2);
    strobe(3);
    take(0);
    wr(3'h1, 16'h0e02);
    strobe(2);
    take(0);
    wr(3'h1, 16'h0e06);
    expq.push_back(6);
    take(0);
    freq = 4'h0;
    repeat (8) @(negedge clk);
    for (int m = 1; m < 3; m++) begin
      wmode = m[1:0];
      inwin = (m == 2);
      strobe(10);
      rd(3'h2, 16'h0000);
      inwin = (m == 1);
      strobe(10);
      rd(3'h2, 16'h0800);
      strobe(2);
      expq.push_back(4);
      take(0);
    end
    dsp = 1'b1;
    repeat (6) @(negedge clk);
    dsp = 1'b0;
    rd(3'h2, 16'h0400);
    strobe(2);
    expq.push_back(3);
    take(0);
    sdat = 32'h0040_0000;
    strobe(4);
    expq.push_back(7);
    take(0);
    hw(1'b1, 16'h8200);
    @(negedge clk);
    chk({30'h0, halt, nonmaskable_context_sel}, 32'h3);
    chk({16'h0, host_control_high_reg}, 32'h8200);
    strobe(5);
    take(0);
    hw(1'b1, 16'h0100);
    expq.push_back(1);
    expq.push_back(8);
    take(0);
    wr(3'h3, 16'h0100);
    expq.push_back(1);
    take(0);
    hw(1'b0, 16'h0080);
    @(negedge clk);
    chk({31'h0, host_irq_out}, 32'h1);
    chk({16'h0, host_control_low_reg}, 32'h80);
    hw(1'b1, 16'h0280);
    wt(1'b1);
    wt(1'b0);
    rd(3'h4, 16'h0000);
    rd(3'h3, 16'h0000);
    freq = 4'h8;
    wt(1'b1);
    freq = 4'h0;
    wt(1'b0);
    rd(3'h3, 16'h0000);
    summarize();
  end
endmodule : tb_processor_interrupt_control
